// ---- verilog/dscd_params.svh ----
// Constants for the serial command decoder
`ifndef DSCD_PARAMS_SVH
`define DSCD_PARAMS_SVH
`define DSCD_WORD_BITS     24
`define DSCD_RW_BIT        23
`define DSCD_REG_HI        21
`define DSCD_REG_LO        19
`define DSCD_CH_HI         18
`define DSCD_CH_LO         16
`define DSCD_REG_FUNC      3'h0
`define DSCD_REG_DATA      3'h2
`define DSCD_REG_CGAIN     3'h3
`define DSCD_REG_FGAIN     3'h4
`define DSCD_REG_OFFS      3'h5
`define DSCD_CH_A          3'h0
`define DSCD_CH_B          3'h1
`define DSCD_CH_BOTH       3'h4
`define DSCD_FN_NOP        3'h0
`define DSCD_FN_CTRL       3'h1
`define DSCD_FN_CLEAR      3'h4
`define DSCD_FN_LOAD       3'h5
`define DSCD_CTRL_RESET    6'h00
`define DSCD_ZERO_TWOS     16'h0000
`define DSCD_ZERO_BIN      16'h8000
`define DSCD_NEG_FS_TWOS   16'h8000
`define DSCD_NEG_FS_BIN    16'h0000
`endif

// ---- verilog/dscd_pkg.sv ----
// Types for the serial command decoder
package dscd_pkg;
  typedef enum logic [1:0] {DSCD_IDLE, DSCD_SHIFT, DSCD_DONE} dscd_state_e;
endpackage

// ---- verilog/dscd_sync.sv ----
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module dscd_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic [WIDTH-1:0] async_i,
  input  wire logic [WIDTH-1:0] rst_val_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta;
  // First stage only feeds the second
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      meta   <= rst_val_i;
      sync_o <= rst_val_i;
    end
    else
    begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/dscd_top.sv ----
// Serial command decoder for a dual 16-bit DAC
`timescale 1ns/1ps
`default_nettype none
`include "dscd_params.svh"
// Operation
// - A falling edge on the clear pin sets both DAC outputs to the clear code, 0x0000 for either coding pin level.
// - After the clear pin rises the outputs keep the cleared code until reprogrammed.
// - A clear pin held low during reset loads the clear code into both DAC outputs.
// - The word 0x04XXXX performs the same clear as the pin, data ignored.
// - Bit 23 of each word marks read (1) or write (0) of the addressed register.
// - Bits 21..19 select function, data, coarse gain, fine gain or offset register.
// - Bits 18..16 select channel A (000), channel B (001) or both (100).
// - Register select 000 makes the word a function chosen by the channel bits alone, data bits as its argument.
// - Function channel 000 is a no-operation that changes nothing.
// - Function channel 001 writes the six control bits from data bits 5..0.
// - Function channel 100 clears the outputs whatever the data.
// - Function channel 101 copies input registers into the output registers.
// - Only frames of exactly 24 falling clock edges are latched, on the frame-select rise.
// - After a read word the selected register shifts out during the next frame.
// - The serial output disable bit turns the serial output off, and resets to zero.
module dscd_top
  import dscd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        sclk_i,
  input  wire logic        frame_n_i,
  input  wire logic        sdin_i,
  input  wire logic        async_clear_pin_n_i,
  input  wire logic        coding_select_pin_i,
  input  wire logic        load_n_i,
  input  wire logic [1:0]  general_io_in_i,
  output logic             sdo_o,
  output logic             sdo_oe_o,
  output logic [15:0]      dac_a_o,
  output logic [15:0]      dac_b_o,
  output logic [1:0]       coarse_a_o,
  output logic [1:0]       coarse_b_o,
  output logic [5:0]       fine_a_o,
  output logic [5:0]       fine_b_o,
  output logic [7:0]       offset_a_o,
  output logic [7:0]       offset_b_o,
  output logic             ground_trim_en_o,
  output logic [1:0]       general_io_out_o,
  output logic [1:0]       general_io_oe_o,
  output logic             frame_error_o
);
  logic [5:0]       pins_s;
  logic             sclk_s;
  logic             frame_n_s;
  logic             sdin_s;
  logic             clr_n_s;
  logic             coding_s;
  logic             load_n_s;
  logic [1:0]       gpio_s;
  logic             sclk_d;
  logic             frame_n_d;
  logic             clr_n_d;
  logic             load_n_d;
  dscd_state_e      state;
  logic [23:0]      shreg;
  logic [4:0]       edge_cnt;
  logic [23:0]      rd_shift;
  logic [23:0]      rd_word;
  logic             rd_pending;
  logic [15:0]      in_a;
  logic [15:0]      in_b;
  logic [5:0]       ctrl;
  logic             word_ok;
  logic             do_clear;
  logic             do_load;
  logic [15:0]      clear_code;
  logic [2:0]       reg_sel;
  logic [2:0]       ch_sel;
  logic             is_write;
  logic             hit_a;
  logic             hit_b;
  logic [1:0]       hits;

  // Pin synchronisers, idle levels at reset
  dscd_sync #(
    .WIDTH(6)
  ) u_sync (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .async_i  ({sclk_i, frame_n_i, sdin_i, async_clear_pin_n_i,
                coding_select_pin_i, load_n_i}),
    .rst_val_i(6'h3d),
    .sync_o   (pins_s)
  );
  assign sclk_s    = pins_s[5];
  assign frame_n_s = pins_s[4];
  assign sdin_s    = pins_s[3];
  assign clr_n_s   = pins_s[2];
  assign coding_s  = pins_s[1];
  assign load_n_s  = pins_s[0];

  dscd_sync #(
    .WIDTH(2)
  ) u_sync_io (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .async_i  (general_io_in_i),
    .rst_val_i(2'h0),
    .sync_o   (gpio_s)
  );

  // Channel decode, shared by writes and reads
  function automatic logic [1:0] ch_hits(input logic [2:0] ch);
    case (ch)
      `DSCD_CH_A:    ch_hits = 2'h1;
      `DSCD_CH_B:    ch_hits = 2'h2;
      `DSCD_CH_BOTH: ch_hits = 2'h3;
      default:       ch_hits = 2'h0;
    endcase
  endfunction

  // Edge history; idle-high reset makes a clear pin held low act as a fall
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      sclk_d    <= 1'b1;
      frame_n_d <= 1'b1;
      clr_n_d   <= 1'b1;
      load_n_d  <= 1'b1;
    end
    else
    begin
      sclk_d    <= sclk_s;
      frame_n_d <= frame_n_s;
      clr_n_d   <= clr_n_s;
      load_n_d  <= load_n_s;
    end
  end

  // Frame state: count falling clock edges while frame select is low
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      state    <= DSCD_IDLE;
      edge_cnt <= 5'h00;
      shreg    <= 24'h000000;
    end
    else
    begin
      case (state)
        DSCD_IDLE:
        begin
          edge_cnt <= 5'h00;
          if (frame_n_d && !frame_n_s)
            state <= DSCD_SHIFT;
        end
        DSCD_SHIFT:
        begin
          if (frame_n_s)
            state <= DSCD_DONE;
          else if (sclk_d && !sclk_s)
          begin
            shreg <= {shreg[22:0], sdin_s};
            if (edge_cnt != 5'h1f)
              edge_cnt <= edge_cnt + 5'h01;
          end
        end
        DSCD_DONE:
          state <= DSCD_IDLE;
        default:
          state <= DSCD_IDLE;
      endcase
    end
  end

  // Word fields, valid only on exactly 24 edges
  assign word_ok  = (state == DSCD_DONE) &&
                    (edge_cnt == 5'(`DSCD_WORD_BITS));
  assign reg_sel  = shreg[`DSCD_REG_HI:`DSCD_REG_LO];
  assign ch_sel   = shreg[`DSCD_CH_HI:`DSCD_CH_LO];
  assign is_write = !shreg[`DSCD_RW_BIT];
  assign hits     = ch_hits(ch_sel);
  assign hit_a    = hits[0];
  assign hit_b    = hits[1];
  assign clear_code = coding_s ? `DSCD_NEG_FS_BIN : `DSCD_ZERO_TWOS;

  // Function commands: clear and load
  assign do_clear = (clr_n_d && !clr_n_s) ||
                    (word_ok && is_write && reg_sel == `DSCD_REG_FUNC &&
                     ch_sel == `DSCD_FN_CLEAR);
  assign do_load  = (load_n_d && !load_n_s) ||
                    (word_ok && is_write && reg_sel == `DSCD_REG_FUNC &&
                     ch_sel == `DSCD_FN_LOAD);

  // Register writes; undefined codes fall through untouched
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      in_a       <= `DSCD_ZERO_TWOS;
      in_b       <= `DSCD_ZERO_TWOS;
      coarse_a_o <= 2'h0;
      coarse_b_o <= 2'h0;
      fine_a_o   <= 6'h00;
      fine_b_o   <= 6'h00;
      offset_a_o <= 8'h00;
      offset_b_o <= 8'h00;
      ctrl       <= `DSCD_CTRL_RESET;
    end
    else if (word_ok && is_write)
    begin
      case (reg_sel)
        `DSCD_REG_FUNC:
          if (ch_sel == `DSCD_FN_CTRL)
            ctrl <= shreg[5:0];
          // NOP and others leave state alone
        `DSCD_REG_DATA:
        begin
          if (hit_a) in_a <= shreg[15:0];
          if (hit_b) in_b <= shreg[15:0];
        end
        `DSCD_REG_CGAIN:
        begin
          if (hit_a) coarse_a_o <= shreg[1:0];
          if (hit_b) coarse_b_o <= shreg[1:0];
        end
        `DSCD_REG_FGAIN:
        begin
          if (hit_a) fine_a_o <= shreg[5:0];
          if (hit_b) fine_b_o <= shreg[5:0];
        end
        `DSCD_REG_OFFS:
        begin
          if (hit_a) offset_a_o <= shreg[7:0];
          if (hit_b) offset_b_o <= shreg[7:0];
        end
        default: ;
      endcase
    end
  end

  // DAC registers: clear wins over load, held until reprogrammed
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      dac_a_o <= `DSCD_ZERO_TWOS;
      dac_b_o <= `DSCD_ZERO_TWOS;
    end
    else if (do_clear)
    begin
      dac_a_o <= clear_code;
      dac_b_o <= clear_code;
    end
    else if (do_load)
    begin
      dac_a_o <= in_a;
      dac_b_o <= in_b;
    end
  end

  // Control bit outputs
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      ground_trim_en_o <= 1'b0;
      general_io_out_o <= 2'h0;
      general_io_oe_o  <= 2'h0;
      sdo_oe_o         <= 1'b1;
    end
    else
    begin
      ground_trim_en_o <= ctrl[5];
      general_io_out_o <= {ctrl[3], ctrl[1]};
      general_io_oe_o  <= {ctrl[4], ctrl[2]};
      sdo_oe_o         <= !ctrl[0];
    end
  end

  // Read word capture after a read frame
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      rd_word    <= 24'h000000;
      rd_pending <= 1'b0;
    end
    else if (word_ok)
    begin
      rd_pending <= !is_write;
      rd_word    <= 24'h000000;
      if (!is_write)
      begin
        case (reg_sel)
          `DSCD_REG_FUNC:
            rd_word[5:0] <= {ctrl[5:4],
                             ctrl[4] ? ctrl[3] : gpio_s[1], ctrl[2],
                             ctrl[2] ? ctrl[1] : gpio_s[0], ctrl[0]};
          `DSCD_REG_DATA:  rd_word[15:0] <= hit_b && !hit_a ? in_b : in_a;
          `DSCD_REG_CGAIN: rd_word[1:0] <= hit_b && !hit_a ? coarse_b_o : coarse_a_o;
          `DSCD_REG_FGAIN: rd_word[5:0] <= hit_b && !hit_a ? fine_b_o : fine_a_o;
          `DSCD_REG_OFFS:  rd_word[7:0] <= hit_b && !hit_a ? offset_b_o : offset_a_o;
          default:         rd_word <= 24'h000000;
        endcase
        rd_word[23:16] <= shreg[23:16];
      end
    end
  end

  // Serial output: shifts on rising clock, valid at the falling edge
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      rd_shift <= 24'h000000;
      sdo_o    <= 1'b0;
    end
    else if (state == DSCD_IDLE && frame_n_d && !frame_n_s)
    begin
      rd_shift <= rd_pending ? rd_word : 24'h000000;
      sdo_o    <= rd_pending ? rd_word[23] : 1'b0;
    end
    else if (state == DSCD_SHIFT && !sclk_d && sclk_s && edge_cnt != 5'h00)
    begin
      rd_shift <= {rd_shift[22:0], shreg[23]};
      sdo_o    <= rd_shift[22];
    end
  end

  // Frame length fault flag, cleared by the next good frame
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      frame_error_o <= 1'b0;
    else if (state == DSCD_DONE)
      frame_error_o <= !word_ok;
  end
endmodule
`default_nettype wire

// ---- tb/dscd_top_properties.sv ----
// Port checker for the serial command decoder
`timescale 1ns/1ps
`default_nettype none
module dscd_top_props (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        frame_n_i,
  input wire logic        load_n_i,
  input wire logic        async_clear_pin_n_i,
  input wire logic [15:0] dac_a_o,
  input wire logic [15:0] dac_b_o,
  input wire logic        frame_error_o,
  input wire logic        ground_trim_en_o,
  input wire logic [1:0]  general_io_oe_o,
  input wire logic [7:0]  offset_a_o,
  input wire logic [5:0]  fine_a_o,
  input wire logic [1:0]  coarse_b_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // No frame, load or clear under way
  sequence s_quiet;
    (frame_n_i && load_n_i && async_clear_pin_n_i) [*8];
  endsequence
  // Both outputs at the clear code
  sequence s_cleared;
    dac_a_o == 16'h0000 && dac_b_o == 16'h0000;
  endsequence
  a_clear_pin_zero: assert property ($fell(async_clear_pin_n_i) |-> ##[1:8] s_cleared)
    else $error("outputs not cleared after clear pin fall");
  a_clear_held: assert property (!async_clear_pin_n_i [*8] |-> s_cleared)
    else $error("outputs left the clear code");
  a_dac_idle: assert property (s_quiet |=> $stable(dac_a_o) && $stable(dac_b_o))
    else $error("output code moved without a cause");
  a_error_frame: assert property ($changed(frame_error_o) |-> frame_n_i)
    else $error("frame error moved inside a frame");
  a_trim_frame: assert property ($changed(ground_trim_en_o) |-> frame_n_i)
    else $error("trim enable moved inside a frame");
  a_gpio_frame: assert property (s_quiet |=> $stable(general_io_oe_o))
    else $error("port direction moved without a frame");
  a_offset_frame: assert property ($changed(offset_a_o) |-> frame_n_i)
    else $error("offset moved inside a frame");
  a_fine_frame: assert property (s_quiet |=> $stable(fine_a_o))
    else $error("fine gain moved without a frame");
  a_coarse_frame: assert property ($changed(coarse_b_o) |-> frame_n_i)
    else $error("coarse gain moved inside a frame");
endmodule
bind dscd_top dscd_top_props dscd_top_props_i (
  .clk_i(clk_i), .rstn_i(rstn_i), .frame_n_i(frame_n_i), .load_n_i(load_n_i),
  .async_clear_pin_n_i(async_clear_pin_n_i), .dac_a_o(dac_a_o), .dac_b_o(dac_b_o),
  .frame_error_o(frame_error_o), .ground_trim_en_o(ground_trim_en_o),
  .general_io_oe_o(general_io_oe_o), .offset_a_o(offset_a_o), .fine_a_o(fine_a_o),
  .coarse_b_o(coarse_b_o)
);
`default_nettype wire

// ---- tb/dscd_host.sv ----
// Host serial port model driving command frames
`timescale 1ns/1ps
`default_nettype none
module dscd_host (
  input  wire logic        clk_i,
  input  wire logic        sdo_i,
  output var  logic        sclk_o,
  output var  logic        frame_n_o,
  output var  logic        sdin_o,
  output var  logic [23:0] rd_word_o
);
  initial
  begin
    sclk_o = 1'b1;
    frame_n_o = 1'b1;
    sdin_o = 1'b0;
    rd_word_o = 24'h000000;
  end
  // One frame of n clock falls, sdo gathered at each fall
  task automatic send(input logic [23:0] w, input int n);
    int i;
    @(posedge clk_i);
    frame_n_o <= 1'b0;
    for (i = 0; i < n; i++)
    begin
      sdin_o <= (i == 1) ? 1'b0 : (i < 24) ? w[23 - i] : ~sdin_o;
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b0;
      rd_word_o <= {rd_word_o[22:0], sdo_i};
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
    end
    repeat (4) @(posedge clk_i);
    frame_n_o <= 1'b1;
    sdin_o <= ~sdin_o; // Released line shows no stale bit
    repeat (10) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the serial command decoder
`timescale 1ns/1ps
`default_nettype none
`include "dscd_params.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
  $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tb_top;
  typedef struct packed {logic [23:0] w; logic [3:0] sel; logic [15:0] exp;} dscd_row_s;
  logic        clk, rstn, sclk, frame_n, sdin, clr_n, coding, load_n;
  logic        sdo, sdo_oe, trim, ferr;
  logic [15:0] dac_a, dac_b;
  logic [1:0]  crs_a, crs_b, io_out, io_oe, gpio;
  logic [5:0]  fin_a, fin_b;
  logic [7:0]  off_a, off_b;
  logic [23:0] rd;
  int          n_fail = 0;
  int          n_tests = 0;
  dscd_row_s   rows [18] = '{
    '{24'h101234, 4'h0, 16'h0000}, '{24'h05ffff, 4'h0, 16'h1234},
    '{24'h11abcd, 4'h1, 16'h0000}, '{24'h050000, 4'h1, 16'habcd},
    '{24'h180002, 4'h2, 16'h0002}, '{24'h19ffff, 4'h3, 16'h0003},
    '{24'h24ff15, 4'h4, 16'h0015}, '{24'h000000, 4'h5, 16'h0015},
    '{24'h2800a5, 4'h6, 16'h00a5}, '{24'h29015a, 4'h7, 16'h005a},
    '{24'h01ffe6, 4'h8, 16'h0026}, '{24'h08ffff, 4'h2, 16'h0002},
    '{24'h02ffff, 4'h8, 16'h0026}, '{24'h810000, 4'h8, 16'h0026},
    '{24'h000000, 4'h9, 16'h002e}, '{24'ha00000, 4'h4, 16'h0015},
    '{24'h000000, 4'h9, 16'h0015}, '{24'h04ffff, 4'h0, 16'h0000}};
  dscd_host dscd_host_i (.clk_i(clk), .sdo_i(sdo), .sclk_o(sclk), .frame_n_o(frame_n),
    .sdin_o(sdin), .rd_word_o(rd));
  dscd_top dscd_top_i (.clk_i(clk), .rstn_i(rstn), .sclk_i(sclk), .frame_n_i(frame_n),
    .sdin_i(sdin), .async_clear_pin_n_i(clr_n), .coding_select_pin_i(coding),
    .load_n_i(load_n), .general_io_in_i(gpio), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .dac_a_o(dac_a), .dac_b_o(dac_b), .coarse_a_o(crs_a), .coarse_b_o(crs_b),
    .fine_a_o(fin_a), .fine_b_o(fin_b), .offset_a_o(off_a), .offset_b_o(off_b),
    .ground_trim_en_o(trim), .general_io_out_o(io_out), .general_io_oe_o(io_oe),
    .frame_error_o(ferr));
  // Output picked by a row
  function automatic logic [15:0] obs(input logic [3:0] s);
    case (s)
      4'h0: return dac_a;
      4'h1: return dac_b;
      4'h2: return {14'h0, crs_a};
      4'h3: return {14'h0, crs_b};
      4'h4: return {10'h0, fin_a};
      4'h5: return {10'h0, fin_b};
      4'h6: return {8'h0, off_a};
      4'h7: return {8'h0, off_b};
      4'h8: return {10'h0, trim, io_oe[1], io_out[1], io_oe[0], io_out[0], ~sdo_oe};
      default: return rd[15:0];
    endcase
  endfunction
  // Counts, verdict and end of run
  task automatic give_verdict();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Main sequence
  initial
  begin
    {rstn, clr_n, coding, load_n} = 4'b0101;
    gpio = 2'h2;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(sdo_oe, 1'b1)
    `CHK(ferr, 1'b0)
    $display("reset test done");
    foreach (rows[k])
    begin
      dscd_host_i.send(rows[k].w, 24);
      `CHK(obs(rows[k].sel), rows[k].exp)
    end
    $display("table test done");
    dscd_host_i.send(24'h010001, 24);
    `CHK(sdo_oe, 1'b0)
    dscd_host_i.send(24'h105555, 24);
    `CHK(ferr, 1'b0)
    dscd_host_i.send(24'h10aaaa, 23);
    `CHK(ferr, 1'b1)
    dscd_host_i.send(24'h10aaaa, 25);
    `CHK(ferr, 1'b1)
    load_n <= 1'b0;
    repeat (8) @(posedge clk);
    load_n <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK(dac_a, 16'h5555)
    $display("frame length test done");
    coding <= 1'b1;
    clr_n <= 1'b0;
    repeat (10) @(posedge clk);
    `CHK(dac_a, `DSCD_NEG_FS_BIN)
    clr_n <= 1'b1;
    repeat (20) @(posedge clk);
    `CHK(dac_a, `DSCD_NEG_FS_BIN)
    $display("clear pin test done");
    // Second reset with the clear pin held low
    clr_n <= 1'b0;
    rstn <= 1'b0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK(dac_b, `DSCD_NEG_FS_BIN)
    `CHK(sdo_oe, 1'b1)
    clr_n <= 1'b1;
    dscd_host_i.send(24'h11beef, 24);
    dscd_host_i.send(24'h05ffff, 24);
    `CHK(dac_b, 16'hbeef)
    $display("second reset test done");
    give_verdict();
  end
endmodule
`default_nettype wire
